// ### common/uifc_pkg.sv
// constants, types and helpers for the uart interrupt and fifo control block
// ************************************************************
// Behaviour
// - xoff reception interrupts when enhanced mode and enable bit 5 are set
// - rising request-to-send output interrupts when enable bit 6 and auto rts set
// - rising clear-to-send input interrupts when enable bit 7 and auto cts set
// - source read reports only the highest pending interrupt, others wait
// - line status is level 1, code 000110
// - receive time-out is level 2, code 001100
// - receive data ready level 3 code 000100, transmit ready level 4 code 000010
// - modem 000000, xoff or special 010000, flow change 100000, none 000001
// - line status bits 1 to 4 raise it, line status read clears it
// - four characters plus twelve bits of silence time out, holding read clears
// - receive ready holds while fifo count is at or above trigger level
// - transmit ready from trigger or empty, cleared by source read or write
// - modem status bits 0 to 3 raise it, modem status read clears it
// - xoff cleared by source read or xon; special by read or next character
// - flow change interrupts clear on modem status read only
// - source bits 7 and 6 both mirror the fifo enable
// - fifo control bits other than 0 count only when bit 0 is written 1
// - fifo control bit 1 pulses a receive fifo reset, then self-clears
// - fifo control bit 2 pulses a transmit fifo reset, then self-clears
// - fifo control bit 3 selects normal or dma behaviour of ready pins
// - transmit trigger select 00,01,10,11 gives 16,8,24,30 in enhanced mode
// - receive trigger select 00,01,10,11 gives 8,16,24,30
// - enable bits 0 to 3 mask the four classic interrupt sources
// ************************************************************
package uifc_pkg;
    // register byte addresses
    localparam logic [7:0] UIFC_ADDR_IE   = 8'h00;
    localparam logic [7:0] UIFC_ADDR_SRC  = 8'h04;
    localparam logic [7:0] UIFC_ADDR_FCTL = 8'h08;
    localparam logic [7:0] UIFC_ADDR_ENH  = 8'h0C;
    localparam logic [7:0] UIFC_ADDR_STAT = 8'h10;
    localparam logic [7:0] UIFC_RST_BYTE  = 8'h00;
    // interrupt enable fields
    localparam int UIFC_IE_RX   = 0;
    localparam int UIFC_IE_TX   = 1;
    localparam int UIFC_IE_LS   = 2;
    localparam int UIFC_IE_MS   = 3;
    localparam int UIFC_IE_XOFF = 5;
    localparam int UIFC_IE_RTS  = 6;
    localparam int UIFC_IE_CTS  = 7;
    // fifo control fields
    localparam int UIFC_FC_EN    = 0;
    localparam int UIFC_FC_RXRST = 1;
    localparam int UIFC_FC_TXRST = 2;
    localparam int UIFC_FC_DMA   = 3;
    localparam int UIFC_FC_TXTRG = 4;
    localparam int UIFC_FC_RXTRG = 6;
    // enhanced feature control fields
    localparam int UIFC_ENH_EN  = 4;
    localparam int UIFC_ENH_RTS = 6;
    localparam int UIFC_ENH_CTS = 7;
    // source codes, bits 5:0
    localparam logic [5:0] UIFC_CODE_LS   = 6'h06;
    localparam logic [5:0] UIFC_CODE_TO   = 6'h0C;
    localparam logic [5:0] UIFC_CODE_RX   = 6'h04;
    localparam logic [5:0] UIFC_CODE_TX   = 6'h02;
    localparam logic [5:0] UIFC_CODE_MS   = 6'h00;
    localparam logic [5:0] UIFC_CODE_XOFF = 6'h10;
    localparam logic [5:0] UIFC_CODE_FLOW = 6'h20;
    localparam logic [5:0] UIFC_CODE_NONE = 6'h01;
    // pending vector positions, 0 is highest priority
    localparam int UIFC_NSRC   = 7;
    localparam int UIFC_P_LS   = 0;
    localparam int UIFC_P_TO   = 1;
    localparam int UIFC_P_RX   = 2;
    localparam int UIFC_P_TX   = 3;
    localparam int UIFC_P_MS   = 4;
    localparam int UIFC_P_XOFF = 5;
    localparam int UIFC_P_FLOW = 6;
    // trigger levels and time-out length
    localparam logic [5:0] UIFC_LVL_1  = 6'h01;
    localparam logic [5:0] UIFC_LVL_8  = 6'h08;
    localparam logic [5:0] UIFC_LVL_16 = 6'h10;
    localparam logic [5:0] UIFC_LVL_24 = 6'h18;
    localparam logic [5:0] UIFC_LVL_30 = 6'h1E;
    localparam logic [7:0] UIFC_TO_CHARS = 8'h04;
    localparam logic [7:0] UIFC_TO_BITS  = 8'h0C;
    localparam int UIFC_CNT_W = 6;
    localparam int UIFC_DEPTH = 32;

    // inputs from the rest of the channel
    typedef struct packed {
        logic [3:0] line_status_bits;
        logic [3:0] modem_status_bits;
        logic       line_status_read;
        logic       modem_status_read;
        logic       receive_holding_read;
        logic       transmit_holding_write;
        logic       rx_char_strobe;
        logic       xoff_detect;
        logic       xon_detect;
        logic       special_detect;
        logic       rts_pin;
        logic       cts_pin;
        logic       bit_tick;
    } uifc_evt_t;

    // time-out timer state
    typedef struct packed {
        logic [7:0] cnt;
        logic       done;
        logic       fire;
    } uifc_tmr_st_t;

    // trigger level decode, shared by receive and transmit
    function automatic logic [5:0] uifc_trig(input logic [1:0] sel, input logic is_tx);
        logic [5:0] lvl;
        lvl = UIFC_LVL_30;
        case (sel)
            2'h0: lvl = is_tx ? UIFC_LVL_16 : UIFC_LVL_8;
            2'h1: lvl = is_tx ? UIFC_LVL_8 : UIFC_LVL_16;
            2'h2: lvl = UIFC_LVL_24;
            default: lvl = UIFC_LVL_30;
        endcase
        return lvl;
    endfunction

    // source code by priority position
    function automatic logic [5:0] uifc_src_code(input logic [2:0] idx);
        logic [5:0] c;
        c = UIFC_CODE_NONE;
        case (idx)
            3'h0: c = UIFC_CODE_LS;
            3'h1: c = UIFC_CODE_TO;
            3'h2: c = UIFC_CODE_RX;
            3'h3: c = UIFC_CODE_TX;
            3'h4: c = UIFC_CODE_MS;
            3'h5: c = UIFC_CODE_XOFF;
            3'h6: c = UIFC_CODE_FLOW;
            default: c = UIFC_CODE_NONE;
        endcase
        return c;
    endfunction
endpackage

// ### logic/uifc_prio_enc.sv
// priority encoder from pending sources to the source code
`timescale 1ns/1ps
module uifc_prio_enc #(
    parameter int NSRC = uifc_pkg::UIFC_NSRC
) (
    input  wire logic [NSRC-1:0] pend,
    output logic      [5:0]      code
);
    if (NSRC != uifc_pkg::UIFC_NSRC) begin : g_chk
        $error("uifc_prio_enc: source count must match the code table");
    end

    // walk lowest to highest so the highest pending wins
    always_comb begin
        code = uifc_pkg::UIFC_CODE_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code = uifc_pkg::uifc_src_code(3'(i));
            end
        end
    end
endmodule

// ### logic/uifc_rx_timer.sv
// receive time-out timer counting bit times of line silence
`timescale 1ns/1ps
module uifc_rx_timer (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       restart,
    input  wire logic       armed,
    input  wire logic       bit_tick,
    input  wire logic [3:0] char_bits,
    output logic            fire_q
);
    uifc_pkg::uifc_tmr_st_t s_q;
    uifc_pkg::uifc_tmr_st_t s_d;
    logic [7:0]             limit;

    // four characters plus twelve bits
    assign limit = 8'(8'(char_bits) * uifc_pkg::UIFC_TO_CHARS + uifc_pkg::UIFC_TO_BITS);
    assign fire_q = s_q.fire;

    // count ticks while armed, one fire per quiet spell
    always_comb begin
        s_d = s_q;
        s_d.fire = 1'b0;
        if (restart || !armed) begin
            s_d.cnt  = 8'h00;
            s_d.done = 1'b0;
        end else if (bit_tick && !s_q.done) begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt + 8'h01 >= limit) begin
                s_d.fire = 1'b1;
                s_d.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    fire_limit_a: assert property (@(posedge ref_clk) disable iff (reset)
        s_q.fire |-> s_q.cnt >= $past(limit)) else $error("time-out fired early");
endmodule

// ### logic/uifc_ctrl.sv
// interrupt prioritisation and fifo control for one uart channel, apb slave
`timescale 1ns/1ps
module uifc_ctrl #(
    parameter int CNT_W = uifc_pkg::UIFC_CNT_W,
    parameter int DEPTH = uifc_pkg::UIFC_DEPTH
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire uifc_pkg::uifc_evt_t evt,
    input  wire logic [CNT_W-1:0]    rx_count,
    input  wire logic [CNT_W-1:0]    tx_count,
    input  wire logic [3:0]          char_bits,
    output logic                     irq_q,
    output logic                     rx_fifo_reset_q,
    output logic                     tx_fifo_reset_q,
    output logic                     fifo_enable_q,
    output logic                     dma_mode_q,
    output logic                     receive_ready_pin_n,
    output logic                     transmit_ready_pin_n
);
    if (CNT_W != uifc_pkg::UIFC_CNT_W || DEPTH >= (1 << CNT_W) || DEPTH < 31) begin : g_chk
        $error("uifc_ctrl: counts must be 6 bits wide and depth must reach 31");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] ie;
        logic [7:0] enh;
        logic       fifo_en;
        logic       dma;
        logic [5:0] rx_lvl;
        logic [5:0] tx_lvl;
        logic       rx_rst;
        logic       tx_rst;
        logic       p_ls;
        logic       p_to;
        logic       p_tx;
        logic       p_ms;
        logic       p_xoff;
        logic       p_spec;
        logic       p_rts;
        logic       p_cts;
        logic       tx_over;
        logic       tx_room;
        logic [3:0] prev_ls;
        logic [3:0] prev_ms;
        logic       prev_rts;
        logic       prev_cts;
        logic [5:0] prev_tx;
        logic       irq;
        logic       rxp_n;
        logic       txp_n;
        logic       pready;
        logic       pslverr;
        logic [7:0] prdata;
        logic [5:0] rd_code;
    } uifc_state_t;

    uifc_state_t                 s_q;
    uifc_state_t                 s_d;
    logic [uifc_pkg::UIFC_NSRC-1:0] pend;
    logic [5:0]                  code;
    logic                        tmr_fire;
    logic                        acc;
    logic                        wr;
    logic                        rd;
    logic                        enh_on;
    logic                        rx_at_lvl;
    logic [5:0]                  tx_trg;
    logic                        tx_fell;
    logic                        tx_empty_ev;
    logic                        tx_set;
    logic                        tx_clr;
    logic                        src_clr_x;
    logic                        ls_rise;
    logic                        ms_rise;
    logic                        rts_rise;
    logic                        cts_rise;

    // ************************************************************
    // outputs, all from the state register
    // ************************************************************
    assign prdata               = {24'h000000, s_q.prdata};
    assign pready               = s_q.pready;
    assign pslverr              = s_q.pslverr;
    assign irq_q                = s_q.irq;
    assign rx_fifo_reset_q      = s_q.rx_rst;
    assign tx_fifo_reset_q      = s_q.tx_rst;
    assign fifo_enable_q        = s_q.fifo_en;
    assign dma_mode_q           = s_q.dma;
    assign receive_ready_pin_n  = s_q.rxp_n;
    assign transmit_ready_pin_n = s_q.txp_n;

    // ************************************************************
    // event decode
    // ************************************************************
    // apb completion: the edge where pready is seen high
    assign acc = psel && penable && s_q.pready;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign enh_on = s_q.enh[uifc_pkg::UIFC_ENH_EN];

    // receive level, one character when fifos are off
    assign rx_at_lvl = s_q.fifo_en ? (rx_count >= s_q.rx_lvl) : (rx_count != 6'h00);
    assign tx_trg    = s_q.fifo_en ? s_q.tx_lvl : uifc_pkg::UIFC_LVL_1;

    // transmit: below the trigger, or empty after a short reload
    assign tx_fell     = (s_q.prev_tx >= tx_trg) && (tx_count < tx_trg);
    assign tx_empty_ev = (tx_count == 6'h00) && (s_q.prev_tx != 6'h00);
    assign tx_set      = (s_q.tx_over && tx_fell) || (!s_q.tx_over && tx_empty_ev)
                       || (wr && paddr == uifc_pkg::UIFC_ADDR_IE && pwdata[uifc_pkg::UIFC_IE_TX]
                           && !s_q.ie[uifc_pkg::UIFC_IE_TX] && tx_count == 6'h00); // enable write, no loop

    // a source read clears only what it reported
    assign tx_clr    = evt.transmit_holding_write || (rd && paddr == uifc_pkg::UIFC_ADDR_SRC
                       && s_q.rd_code == uifc_pkg::UIFC_CODE_TX);
    assign src_clr_x = rd && paddr == uifc_pkg::UIFC_ADDR_SRC
                       && s_q.rd_code == uifc_pkg::UIFC_CODE_XOFF;

    // new error and modem bits, and flow pin rising edges
    assign ls_rise  = |(evt.line_status_bits & ~s_q.prev_ls);
    assign ms_rise  = |(evt.modem_status_bits & ~s_q.prev_ms);
    assign rts_rise = evt.rts_pin && !s_q.prev_rts && s_q.enh[uifc_pkg::UIFC_ENH_RTS];
    assign cts_rise = evt.cts_pin && !s_q.prev_cts && s_q.enh[uifc_pkg::UIFC_ENH_CTS];

    // enable masks ahead of the priority encoder
    always_comb begin
        pend = '0;
        pend[uifc_pkg::UIFC_P_LS]   = s_q.p_ls && s_q.ie[uifc_pkg::UIFC_IE_LS];
        pend[uifc_pkg::UIFC_P_TO]   = s_q.p_to && s_q.ie[uifc_pkg::UIFC_IE_RX];
        pend[uifc_pkg::UIFC_P_RX]   = rx_at_lvl && s_q.ie[uifc_pkg::UIFC_IE_RX];
        pend[uifc_pkg::UIFC_P_TX]   = s_q.p_tx && s_q.ie[uifc_pkg::UIFC_IE_TX];
        pend[uifc_pkg::UIFC_P_MS]   = s_q.p_ms && s_q.ie[uifc_pkg::UIFC_IE_MS];
        pend[uifc_pkg::UIFC_P_XOFF] = (s_q.p_xoff || s_q.p_spec) && enh_on
                                      && s_q.ie[uifc_pkg::UIFC_IE_XOFF];
        pend[uifc_pkg::UIFC_P_FLOW] = enh_on && ((s_q.p_rts && s_q.ie[uifc_pkg::UIFC_IE_RTS])
                                      || (s_q.p_cts && s_q.ie[uifc_pkg::UIFC_IE_CTS]));
    end

    uifc_prio_enc #(
        .NSRC (uifc_pkg::UIFC_NSRC)
    ) u_enc (
        .pend (pend),
        .code (code)
    );

    uifc_rx_timer u_tmr (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .restart   (evt.rx_char_strobe || evt.receive_holding_read || s_q.rx_rst),
        .armed     (s_q.fifo_en && rx_count != 6'h00),
        .bit_tick  (evt.bit_tick),
        .char_bits (char_bits),
        .fire_q    (tmr_fire)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rx_rst  = 1'b0;
        s_d.tx_rst  = 1'b0;
        s_d.pready  = psel && penable && !s_q.pready;
        // read data and error are set up with pready
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = uifc_pkg::UIFC_RST_BYTE;
            s_d.rd_code = code;
            if (paddr == uifc_pkg::UIFC_ADDR_IE) begin
                s_d.prdata = s_q.ie;
            end else if (paddr == uifc_pkg::UIFC_ADDR_SRC) begin
                s_d.prdata = {s_q.fifo_en, s_q.fifo_en, code};
            end else if (paddr == uifc_pkg::UIFC_ADDR_FCTL) begin
                s_d.prdata = uifc_pkg::UIFC_RST_BYTE;
            end else if (paddr == uifc_pkg::UIFC_ADDR_ENH) begin
                s_d.prdata = s_q.enh;
            end else if (paddr == uifc_pkg::UIFC_ADDR_STAT) begin
                s_d.prdata = {4'h0, s_q.tx_over, s_q.dma, s_q.fifo_en, s_q.irq};
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        // register writes at the completing edge
        if (wr) begin
            if (paddr == uifc_pkg::UIFC_ADDR_IE) begin
                s_d.ie[3:0] = pwdata[3:0];
                if (enh_on) begin
                    s_d.ie[7:4] = pwdata[7:4];
                end
            end else if (paddr == uifc_pkg::UIFC_ADDR_FCTL) begin
                s_d.fifo_en = pwdata[uifc_pkg::UIFC_FC_EN];
                if (pwdata[uifc_pkg::UIFC_FC_EN]) begin
                    s_d.rx_rst = pwdata[uifc_pkg::UIFC_FC_RXRST];
                    s_d.tx_rst = pwdata[uifc_pkg::UIFC_FC_TXRST];
                    s_d.dma    = pwdata[uifc_pkg::UIFC_FC_DMA];
                    s_d.rx_lvl = uifc_pkg::uifc_trig(pwdata[uifc_pkg::UIFC_FC_RXTRG +: 2], 1'b0);
                    if (enh_on) begin
                        s_d.tx_lvl = uifc_pkg::uifc_trig(pwdata[uifc_pkg::UIFC_FC_TXTRG +: 2], 1'b1);
                    end
                end
            end else if (paddr == uifc_pkg::UIFC_ADDR_ENH) begin
                s_d.enh = pwdata[7:0];
            end
        end
        // sticky sources: a set in the clearing cycle wins
        s_d.p_ls   = ls_rise || (s_q.p_ls && !evt.line_status_read);
        s_d.p_to   = tmr_fire || (s_q.p_to && !evt.receive_holding_read);
        s_d.p_tx   = tx_set || (s_q.p_tx && !tx_clr);
        s_d.p_ms   = ms_rise || (s_q.p_ms && !evt.modem_status_read);
        s_d.p_xoff = evt.xoff_detect || (s_q.p_xoff && !evt.xon_detect && !src_clr_x);
        s_d.p_spec = evt.special_detect || (s_q.p_spec && !evt.rx_char_strobe && !src_clr_x);
        s_d.p_rts  = rts_rise || (s_q.p_rts && !evt.modem_status_read);
        s_d.p_cts  = cts_rise || (s_q.p_cts && !evt.modem_status_read);
        s_d.tx_over = (s_q.tx_over && !tx_set) || (tx_count > tx_trg);
        s_d.tx_room = tx_count < 6'(DEPTH);
        s_d.prev_ls  = evt.line_status_bits;
        s_d.prev_ms  = evt.modem_status_bits;
        s_d.prev_rts = evt.rts_pin;
        s_d.prev_cts = evt.cts_pin;
        s_d.prev_tx  = tx_count;
        s_d.irq      = |pend;
        // ready pins: single character in normal mode; receive level or time-out and transmit room in dma mode
        if (s_q.dma && s_q.fifo_en) begin
            s_d.rxp_n = !(rx_at_lvl || s_q.p_to);
            s_d.txp_n = !s_q.tx_room;
        end else begin
            s_d.rxp_n = (rx_count == 6'h00);
            s_d.txp_n = (tx_count != 6'h00);
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q        <= '0;
            s_q.rx_lvl <= uifc_pkg::UIFC_LVL_8;
            s_q.tx_lvl <= uifc_pkg::UIFC_LVL_16;
            s_q.rxp_n  <= 1'b1;
            s_q.txp_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    ls_first_a: assert property (pend[uifc_pkg::UIFC_P_LS] |-> code == uifc_pkg::UIFC_CODE_LS)
        else $error("line status not reported first");
    to_code_a: assert property (pend[1:0] == 2'b10 |-> code == uifc_pkg::UIFC_CODE_TO)
        else $error("time-out code wrong");
    rx_code_a: assert property (pend[2:0] == 3'b100 |-> code == uifc_pkg::UIFC_CODE_RX)
        else $error("receive ready code wrong");
    none_code_a: assert property (pend == '0 |-> code == uifc_pkg::UIFC_CODE_NONE)
        else $error("idle code wrong");
    ls_clear_a: assert property (evt.line_status_read && !ls_rise |=> !s_q.p_ls)
        else $error("line status not cleared");
    rx_level_a: assert property (s_q.ie[0] && s_q.fifo_en && rx_count >= s_q.rx_lvl
        |-> pend[uifc_pkg::UIFC_P_RX]) else $error("receive level not pending");
    tx_write_a: assert property (evt.transmit_holding_write && !tx_set |=> !s_q.p_tx)
        else $error("transmit ready not cleared");
    ms_clear_a: assert property (evt.modem_status_read && !ms_rise && !rts_rise && !cts_rise
        |=> !s_q.p_ms && !s_q.p_rts && !s_q.p_cts) else $error("modem clear failed");
    xon_clear_a: assert property (evt.xon_detect && !evt.xoff_detect |=> !s_q.p_xoff)
        else $error("xoff not cleared by xon");
    rts_set_a: assert property (rts_rise |=> s_q.p_rts) else $error("rts rise lost");
    src_top_a: assert property (rd && paddr == uifc_pkg::UIFC_ADDR_SRC
        |-> prdata[7:6] == {2{s_q.fifo_en}}) else $error("fifo status bits wrong");
    fc_off_a: assert property (wr && paddr == uifc_pkg::UIFC_ADDR_FCTL && !pwdata[0]
        |=> !s_q.fifo_en && $stable(s_q.dma) && !s_q.rx_rst) else $error("fifo control not ignored");
    rx_rst_a: assert property (wr && paddr == uifc_pkg::UIFC_ADDR_FCTL && pwdata[1:0] == 2'b11
        |=> s_q.rx_rst ##1 !s_q.rx_rst) else $error("receive reset not one pulse");
    irq_track_a: assert property (##1 irq_q == ($past(pend) != '0)) else $error("interrupt output lags");

    fire_cv: cover property (tmr_fire ##[1:20] evt.receive_holding_read);
    tx_cv: cover property (s_q.p_tx ##1 tx_clr);
    prio_cv: cover property (pend[0] && pend[3] ##1 rd);
    dma_cv: cover property (s_q.dma && !s_q.rxp_n);
endmodule

// ### verification/uifc_host.sv
// host model issuing apb transfers to the controller
`timescale 1ns/1ps
module uifc_host (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [7:0]  paddr = 8'h00,
    output logic      [31:0] pwdata = 32'h0
);
    // one transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r, output logic e, output logic to);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        to = 1'b1;
        for (i = 0; i < 20 && to; i++) begin
            @(posedge ref_clk);
            to = (pready !== 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ### verification/tb_uart_interrupt_fifo_control.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/1ps
module tb_uart_interrupt_fifo_control;
    logic                ref_clk = 1'b0;
    logic                reset = 1'b1;
    logic                psel, penable, pwrite, pready, pslverr, irq_q, rx_rst, to, er;
    logic                tx_rst, fen, dma, rxp_n, txp_n;
    logic [5:0]          rx_cnt = 6'h00;
    logic [5:0]          tx_cnt = 6'h00;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    uifc_pkg::uifc_evt_t evt = '0;
    int                  n_errors = 0;
    int                  check_count = 0;

    // free running clock
    initial forever #5 ref_clk = ~ref_clk;

    uifc_host host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    uifc_ctrl uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .rx_count(rx_cnt), .tx_count(tx_cnt), .char_bits(4'hA), .irq_q(irq_q), .rx_fifo_reset_q(rx_rst),
        .tx_fifo_reset_q(tx_rst), .fifo_enable_q(fen), .dma_mode_q(dma), .receive_ready_pin_n(rxp_n),
        .transmit_ready_pin_n(txp_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        host.xfer(w, a, d, rd, er, to);
        if (to) begin
            n_errors++;
            final_report();
        end
    endtask
    // one-cycle event pulse on the channel inputs
    task automatic pulse(input uifc_pkg::uifc_evt_t m);
        @(posedge ref_clk);
        evt <= evt | m;
        @(posedge ref_clk);
        evt <= evt & ~m;
    endtask
    task automatic t_tx;
        acc(1'b1, uifc_pkg::UIFC_ADDR_IE, 8'h02);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h02);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h01);
    endtask
    task automatic t_prio;
        uifc_pkg::uifc_evt_t m;
        m = '0;
        m.line_status_bits = 4'h1;
        m.xoff_detect = 1'b1;
        acc(1'b1, uifc_pkg::UIFC_ADDR_ENH, 8'h10);
        acc(1'b1, uifc_pkg::UIFC_ADDR_IE, 8'h24);
        pulse(m);
        repeat (2) @(posedge ref_clk);
        chk(irq_q, 1'b1);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h06);
        m = '0;
        m.line_status_read = 1'b1;
        pulse(m);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h10);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h01);
    endtask
    task automatic t_fifo;
        acc(1'b1, uifc_pkg::UIFC_ADDR_FCTL, 8'h03);
        @(posedge ref_clk);
        chk(rx_rst, 1'b1);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC1);
        acc(1'b1, uifc_pkg::UIFC_ADDR_FCTL, 8'h02);
        @(posedge ref_clk);
        chk(rx_rst, 1'b0);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h01);
        acc(1'b0, uifc_pkg::UIFC_ADDR_FCTL, 8'h00);
        chk(rd, 32'h0);
        acc(1'b0, 8'h3C, 8'h00);
        chk(er, 1'b1);
    endtask
    // trigger levels, dma pins and transmit fifo reset
    task automatic t_lvl;
        acc(1'b1, uifc_pkg::UIFC_ADDR_FCTL, 8'h4D);
        @(posedge ref_clk);
        chk(tx_rst, 1'b1);
        chk({fen, dma}, 2'h3);
        tx_cnt <= 6'h14;
        acc(1'b1, uifc_pkg::UIFC_ADDR_IE, 8'h03);
        rx_cnt <= 6'h0F;
        tx_cnt <= 6'h0A;
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC2);
        rx_cnt <= 6'h10;
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC4);
        chk({rxp_n, txp_n}, 2'h0);
        rx_cnt <= 6'h0F;
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC1);
    endtask
    // clear-to-send rise and modem status, cleared by modem status read
    task automatic t_flow;
        uifc_pkg::uifc_evt_t m;
        m = '0;
        m.cts_pin = 1'b1;
        acc(1'b1, uifc_pkg::UIFC_ADDR_ENH, 8'h90);
        acc(1'b1, uifc_pkg::UIFC_ADDR_IE, 8'h88);
        pulse(m);
        repeat (2) begin
            acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
            chk(rd, 32'hE0);
        end
        m = '0;
        m.modem_status_bits = 4'h1;
        pulse(m);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC0);
        m = '0;
        m.modem_status_read = 1'b1;
        pulse(m);
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'hC1);
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        acc(1'b0, uifc_pkg::UIFC_ADDR_SRC, 8'h00);
        chk(rd, 32'h01);
        t_tx();
        t_prio();
        t_fifo();
        t_lvl();
        t_flow();
        final_report();
    end
endmodule
